// ==== lq_map.svh ====
`ifndef LQ_MAP_SVH
`define LQ_MAP_SVH
// Framing bytes
`define SOH_BYTE          8'h01
`define ETX_BYTE          8'h03
`define REPLY_START       8'h81
// Command and response codes
`define CMD_PROTECT_QRY   8'h73
`define CMD_AUTH_QRY      8'h75
`define RES_PROTECT_ERR   8'hF3
`define RES_AUTH_ERR      8'hF5
`define QUERY_LEN         16'h0001
`define OK_LEN_LOW        8'h02
`define ERR_LEN_LOW       8'h0A
`define OK_BYTES          4'h7
`define ERR_BYTES         4'hF
// Status codes
`define STS_PACKET_ERR    8'hC1
`define STS_CHECKSUM_ERR  8'hC2
`define STS_ACCEPT_ERR    8'hC3
`define UNUSED_BYTE       8'hFF
// Level and lifecycle codes, reset values
`define LIFECYCLE_RMA     8'h07
`define PROTECT_RESET     8'h04
`define AUTH_RESET        8'h04
`define LIFECYCLE_RESET   8'h04
// Register offsets and fields
`define ADDR_STATUS       4'h0
`define ADDR_MASK         4'h4
`define ADDR_LEVEL        4'h8
`define ADDR_CTRL         4'hC
`define EV_OK_BIT         0
`define EV_ERR_BIT        1
`define EV_ERASE_BIT      2
`define PROT_LSB          0
`define AUTH_LSB          8
`define LIFE_LSB          16
`define CTRL_ENC_BIT      0
`endif

// ==== level_query_pkg.sv ====
`default_nettype none
package level_query_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_type;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] len;
    logic        etx_ok;
    logic        sum_ok;
    logic        fmt_ok;
  } rx_result_type;
  typedef struct packed {
    logic       is_err;
    logic [7:0] res;
    logic [7:0] value;
  } reply_req_type;
  typedef struct packed {
    logic       valid;
    logic       key_ok;
    logic       to_lifecycle;
    logic [7:0] target;
  } auth_req_type;
  typedef struct packed {
    logic start;
    logic ignore_bps;
    logic ignore_sec_bps;
  } erase_cmd_type;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_LEN_HI = 3'b001, RX_LEN_LO = 3'b011,
    RX_BODY = 3'b010, RX_SUM = 3'b110, RX_ETX = 3'b111
  } rx_state_type;
  function automatic logic [7:0] add8(input logic [7:0] a,
                                      input logic [7:0] b);
    add8 = a + b;
  endfunction
endpackage
`default_nettype wire

// ==== packet_rx.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lq_map.svh"
module packet_rx (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire level_query_pkg::byte_beat_type rx_in,
  output logic                               done,
  output level_query_pkg::rx_result_type     result
);
  level_query_pkg::rx_state_type state_reg;
  logic [15:0] len_reg;
  logic [15:0] cnt_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  d;
  assign d = rx_in.data;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= level_query_pkg::RX_IDLE;
      len_reg   <= 16'h0000;
      cnt_reg   <= 16'h0000;
      acc_reg   <= 8'h00;
      cmd_reg   <= 8'h00;
      done      <= 1'b0;
      result    <= '0;
    end else begin
      done <= 1'b0;
      if (rx_in.valid) begin
        case (state_reg)
          level_query_pkg::RX_IDLE: begin
            if (d == `SOH_BYTE)
              state_reg <= level_query_pkg::RX_LEN_HI;
          end
          level_query_pkg::RX_LEN_HI: begin
            len_reg[15:8] <= d;
            acc_reg       <= d;
            cmd_reg       <= 8'h00;
            state_reg     <= level_query_pkg::RX_LEN_LO;
          end
          level_query_pkg::RX_LEN_LO: begin
            len_reg[7:0] <= d;
            acc_reg      <= level_query_pkg::add8(acc_reg, d);
            cnt_reg      <= 16'h0000;
            // An empty body goes straight to the checksum byte
            state_reg <= ({len_reg[15:8], d} == 16'h0000) ?
                         level_query_pkg::RX_SUM : level_query_pkg::RX_BODY;
          end
          level_query_pkg::RX_BODY: begin
            if (cnt_reg == 16'h0000)
              cmd_reg <= d;
            acc_reg <= level_query_pkg::add8(acc_reg, d);
            cnt_reg <= cnt_reg + 16'h0001;
            if (cnt_reg + 16'h0001 == len_reg)
              state_reg <= level_query_pkg::RX_SUM;
          end
          level_query_pkg::RX_SUM: begin
            acc_reg   <= level_query_pkg::add8(acc_reg, d);
            state_reg <= level_query_pkg::RX_ETX;
          end
          level_query_pkg::RX_ETX: begin
            done          <= 1'b1;
            result.cmd    <= cmd_reg;
            result.len    <= len_reg;
            result.etx_ok <= (d == `ETX_BYTE);
            result.sum_ok <= (acc_reg == 8'h00);
            result.fmt_ok <= (len_reg != 16'h0000);
            state_reg     <= level_query_pkg::RX_IDLE;
          end
          default: state_reg <= level_query_pkg::RX_IDLE;
        endcase
      end
    end
  end

  soh_wait_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == level_query_pkg::RX_IDLE && rx_in.valid &&
    d != `SOH_BYTE |=> state_reg == level_query_pkg::RX_IDLE)
    else $error("non start byte left the wait state");
endmodule
`default_nettype wire

// ==== reply_tx.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lq_map.svh"
module reply_tx (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          start,
  input  wire level_query_pkg::reply_req_type req,
  input  wire logic                          tx_ready,
  output level_query_pkg::byte_beat_type     tx_out,
  output logic                               busy
);
  level_query_pkg::reply_req_type req_reg;
  logic [3:0] idx_reg;
  logic [7:0] acc_reg;
  logic [3:0] last_idx;
  logic [7:0] acc_next;
  logic [7:0] next_byte;

  function automatic logic [7:0] byte_at(
      input level_query_pkg::reply_req_type r, input logic [3:0] i,
      input logic [3:0] last);
    case (i)
      4'h0: byte_at = `REPLY_START;
      4'h1: byte_at = 8'h00;
      4'h2: byte_at = r.is_err ? `ERR_LEN_LOW : `OK_LEN_LOW;
      4'h3: byte_at = r.res;
      4'h4: byte_at = r.value;
      default: byte_at = (i == last) ? `ETX_BYTE : `UNUSED_BYTE;
    endcase
  endfunction

  assign busy     = tx_out.valid;
  assign last_idx = req_reg.is_err ? `ERR_BYTES - 4'h1 : `OK_BYTES - 4'h1;
  // Bytes from the length high byte up to the last data byte are summed
  assign acc_next = (idx_reg != 4'h0 && idx_reg < last_idx - 4'h1) ?
                    level_query_pkg::add8(acc_reg, tx_out.data) : acc_reg;
  assign next_byte = (idx_reg + 4'h1 == last_idx - 4'h1) ?
                     8'h00 - acc_next :
                     byte_at(req_reg, idx_reg + 4'h1, last_idx);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
      idx_reg <= 4'h0;
      acc_reg <= 8'h00;
      tx_out  <= '0;
    end else if (start && !tx_out.valid) begin
      req_reg     <= req;
      idx_reg     <= 4'h0;
      acc_reg     <= 8'h00;
      tx_out.valid <= 1'b1;
      tx_out.data <= `REPLY_START;
    end else if (tx_out.valid && tx_ready) begin
      if (idx_reg == last_idx) begin
        tx_out.valid <= 1'b0;
      end else begin
        idx_reg     <= idx_reg + 4'h1;
        acc_reg     <= acc_next;
        tx_out.data <= next_byte;
      end
    end
  end

  sequence reply_begins;
    start && !tx_out.valid;
  endsequence
  sequence head_sent;
    tx_out.valid && tx_out.data == `REPLY_START && idx_reg == 4'h0;
  endsequence
  reply_head_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    reply_begins |=> head_sent)
    else $error("reply did not open with the start byte");
  unused_fill_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    tx_out.valid && req_reg.is_err && idx_reg > 4'h4 &&
    idx_reg < 4'hD |-> tx_out.data == `UNUSED_BYTE)
    else $error("detail or address byte not unused code");
  reply_sum_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    tx_out.valid && idx_reg == last_idx - 4'h1 |->
    level_query_pkg::add8(tx_out.data, acc_reg) == 8'h00)
    else $error("reply checksum wrong");
endmodule
`default_nettype wire

// ==== level_query_cmd_handler.sv ====
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "lq_map.svh"
module level_query_cmd_handler (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire level_query_pkg::byte_beat_type rx_in,
  input  wire logic                          tx_ready,
  output level_query_pkg::byte_beat_type     tx_out,
  input  wire logic [3:0]                    addr,
  input  wire logic [31:0]                   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic [31:0]                        rdata,
  input  wire level_query_pkg::auth_req_type  auth_req,
  output level_query_pkg::erase_cmd_type     erase_cmd,
  output logic                               irq
);
  logic                           rx_done;
  level_query_pkg::rx_result_type rx_res;
  logic                           tx_busy;

  logic [7:0]  protect_level_reg;
  logic [7:0]  auth_level_reg;
  logic [7:0]  lifecycle_state_reg;
  logic        enc_pending_reg;
  logic [2:0]  status_reg;
  logic [2:0]  status_next;
  logic [2:0]  mask_reg;
  logic [2:0]  mask_next;
  logic [2:0]  events;

  logic                           reply_start_reg;
  level_query_pkg::reply_req_type reply_reg;
  level_query_pkg::reply_req_type reply_next;

  logic       is_protect_qry;
  logic       is_query;
  logic       take;
  logic       has_error;
  logic [7:0] status_code;
  logic       rma_entry;

  packet_rx u_rx (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .rx_in   (rx_in),
    .done    (rx_done),
    .result  (rx_res)
  );

  reply_tx u_tx (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (reply_start_reg),
    .req      (reply_reg),
    .tx_ready (tx_ready),
    .tx_out   (tx_out),
    .busy     (tx_busy)
  );

  // Only the two level queries are answered here; any other command
  // code, or an empty body, is left for the other command handlers.
  assign is_protect_qry = rx_res.cmd == `CMD_PROTECT_QRY;
  assign is_query       = is_protect_qry ||
                          rx_res.cmd == `CMD_AUTH_QRY;
  // A query finishing while a reply is still going out is dropped:
  // the host waits for each answer before its next command.
  assign take = rx_done && is_query && !tx_busy;

  always_comb begin
    has_error   = 1'b1;
    status_code = `STS_PACKET_ERR;
    if (!rx_res.etx_ok) begin
      status_code = `STS_PACKET_ERR;
    end else if (!rx_res.sum_ok) begin
      status_code = `STS_CHECKSUM_ERR;
    end else if (!rx_res.fmt_ok) begin
      status_code = `STS_PACKET_ERR;
    end else if (rx_res.len != `QUERY_LEN) begin
      status_code = `STS_PACKET_ERR;
    end else if (enc_pending_reg) begin
      status_code = `STS_ACCEPT_ERR;
    end else begin
      has_error = 1'b0;
    end
  end

  always_comb begin
    reply_next = '0;
    reply_next.is_err = has_error;
    if (has_error) begin
      reply_next.res   = is_protect_qry ? `RES_PROTECT_ERR
                                        : `RES_AUTH_ERR;
      reply_next.value = status_code;
    end else begin
      reply_next.res   = rx_res.cmd;
      reply_next.value = is_protect_qry ? protect_level_reg
                                        : auth_level_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reply_start_reg <= 1'b0;
      reply_reg       <= '0;
    end else begin
      reply_start_reg <= take;
      if (take)
        reply_reg <= reply_next;
    end
  end

  // Levels change only through authentication or a software write;
  // a query, good or bad, never touches them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      protect_level_reg <= `PROTECT_RESET;
    end else if (wr && addr == `ADDR_LEVEL) begin
      protect_level_reg <= wdata[`PROT_LSB +: 8];
    end
  end

  assign rma_entry = auth_req.valid && auth_req.key_ok &&
                     auth_req.to_lifecycle &&
                     auth_req.target == `LIFECYCLE_RMA;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      auth_level_reg      <= `AUTH_RESET;
      lifecycle_state_reg <= `LIFECYCLE_RESET;
    end else if (auth_req.valid && auth_req.key_ok) begin
      if (auth_req.to_lifecycle)
        lifecycle_state_reg <= auth_req.target;
      else
        auth_level_reg <= auth_req.target;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      erase_cmd <= '0;
    end else begin
      erase_cmd.start          <= rma_entry;
      erase_cmd.ignore_bps     <= rma_entry;
      erase_cmd.ignore_sec_bps <= rma_entry;
    end
  end

  // Flag can only be cleared by a device reset, never by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enc_pending_reg <= 1'b0;
    end else if (wr && addr == `ADDR_CTRL && wdata[`CTRL_ENC_BIT]) begin
      enc_pending_reg <= 1'b1;
    end
  end

  always_comb begin
    events = 3'h0;
    events[`EV_OK_BIT]    = take && !has_error;
    events[`EV_ERR_BIT]   = take && has_error;
    events[`EV_ERASE_BIT] = rma_entry;
  end

  // New mask counts at once, so irq never lags a mask write
  always_comb begin
    mask_next = mask_reg;
    if (wr && addr == `ADDR_MASK)
      mask_next = wdata[2:0];
  end

  // Read clears, but an event in the same cycle still lands
  always_comb begin
    status_next = status_reg;
    if (rd && addr == `ADDR_STATUS)
      status_next = 3'h0;
    status_next = status_next | events;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= 3'h0;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_next);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          `ADDR_STATUS: rdata <= {29'h0000_0000, status_reg};
          `ADDR_MASK:   rdata <= {29'h0000_0000, mask_reg};
          `ADDR_LEVEL:  rdata <= {8'h00, lifecycle_state_reg,
                                  auth_level_reg, protect_level_reg};
          `ADDR_CTRL:   rdata <= {31'h0000_0000, enc_pending_reg};
          default:      rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  sequence query_done;
    rx_done && is_query && !tx_busy;
  endsequence
  sequence frame_clean;
    rx_res.etx_ok && rx_res.sum_ok && rx_res.fmt_ok;
  endsequence
  sequence err_reply(logic [7:0] code);
    reply_start_reg && reply_reg.is_err && reply_reg.value == code;
  endsequence

  etx_missing_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and !rx_res.etx_ok |=> err_reply(`STS_PACKET_ERR))
    else $error("missing end byte not a packet error");
  sum_mismatch_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and rx_res.etx_ok && !rx_res.sum_ok
    |=> err_reply(`STS_CHECKSUM_ERR))
    else $error("bad checksum not a checksum error");
  length_bad_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and rx_res.etx_ok && rx_res.sum_ok &&
    rx_res.len != `QUERY_LEN |=> err_reply(`STS_PACKET_ERR))
    else $error("bad length not a packet error");
  accept_err_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and frame_clean and rx_res.len == `QUERY_LEN &&
    enc_pending_reg |=> err_reply(`STS_ACCEPT_ERR))
    else $error("query after encrypted write was accepted");
  err_code_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and has_error && !is_protect_qry
    |=> reply_start_reg && reply_reg.is_err &&
        reply_reg.res == `RES_AUTH_ERR)
    else $error("auth query error reply code wrong");
  prot_err_code_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and has_error && is_protect_qry
    |=> reply_start_reg && reply_reg.is_err &&
        reply_reg.res == `RES_PROTECT_ERR)
    else $error("protection query error reply code wrong");
  level_reply_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and frame_clean and rx_res.len == `QUERY_LEN &&
    !enc_pending_reg && is_protect_qry
    |=> reply_start_reg && !reply_reg.is_err &&
        reply_reg.res == `CMD_PROTECT_QRY &&
        reply_reg.value == $past(protect_level_reg))
    else $error("protection level reply wrong");
  auth_reply_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and frame_clean and rx_res.len == `QUERY_LEN &&
    !enc_pending_reg && !is_protect_qry
    |=> reply_start_reg && !reply_reg.is_err &&
        reply_reg.res == `CMD_AUTH_QRY &&
        reply_reg.value == $past(auth_level_reg))
    else $error("authentication level reply wrong");
  prio_etx_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and !rx_res.etx_ok && !rx_res.sum_ok
    |=> err_reply(`STS_PACKET_ERR))
    else $error("end byte error did not outrank checksum");
  prio_len_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    query_done and frame_clean and rx_res.len != `QUERY_LEN &&
    enc_pending_reg |=> err_reply(`STS_PACKET_ERR))
    else $error("length error did not outrank acceptance error");
  levels_kept_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !auth_req.valid && !(wr && addr == `ADDR_LEVEL)
    |=> $stable(protect_level_reg) && $stable(auth_level_reg) &&
        $stable(lifecycle_state_reg))
    else $error("level changed without authentication or write");
  auth_move_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    auth_req.valid && auth_req.key_ok && !auth_req.to_lifecycle
    |=> auth_level_reg == $past(auth_req.target))
    else $error("verified authentication did not move level");
  rma_erase_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    rma_entry |=> erase_cmd.start && erase_cmd.ignore_bps &&
    erase_cmd.ignore_sec_bps && lifecycle_state_reg == `LIFECYCLE_RMA)
    else $error("return merchandise entry did not erase");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    |(status_reg & mask_reg) |-> irq)
    else $error("interrupt low with unmasked status");
  erase_only_rma_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !rma_entry |=> !erase_cmd.start && !erase_cmd.ignore_bps &&
    !erase_cmd.ignore_sec_bps)
    else $error("erase without return merchandise entry");
  status_set_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    events != 3'h0 |=> (status_reg & $past(events)) == $past(events))
    else $error("status event lost to read clear");
  rdata_idle_a: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data shown without a read");
endmodule
`default_nettype wire

// ==== host_tool_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_tool_model (
  input  wire logic                           clk_sys,
  input  wire level_query_pkg::byte_beat_type tx_out,
  input  wire logic                           slow,
  output var level_query_pkg::byte_beat_type  rx_in,
  output var logic                            tx_ready
);
  logic [7:0] got[$];
  logic [7:0] stall = 8'hA5;
  initial rx_in = '0;
  initial tx_ready = 1'b1;
  // Idle line shows the inverse of the last byte, never a stale copy
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_sys);
    rx_in <= '{valid: 1'b1, data: b};
    @(posedge clk_sys);
    rx_in <= '{valid: 1'b0, data: ~b};
  endtask
  // Flip lets a scenario spoil the checksum on purpose
  task automatic send(input logic [15:0] len, input logic [7:0] body[$],
                      input logic [7:0] flip, input logic [7:0] end_b);
    logic [7:0] s;
    s = len[15:8] + len[7:0];
    foreach (body[i]) s += body[i];
    send_byte(8'h01);
    send_byte(len[15:8]);
    send_byte(len[7:0]);
    foreach (body[i]) send_byte(body[i]);
    send_byte((8'h00 - s) ^ flip);
    send_byte(end_b);
  endtask
  // Random stalls check that each reply byte is held until taken
  always @(posedge clk_sys) begin
    if (tx_out.valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_out.data);
    end
    stall <= {stall[6:0], stall[7] ^ stall[5] ^ stall[4] ^ stall[3]};
    tx_ready <= !slow || stall[0];
  end
endmodule
`default_nettype wire

// ==== test_level_query_cmd_handler.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_level_query_cmd_handler;
  logic                           clk_sys = 1'b0;
  logic                           rst_n = 1'b0;
  level_query_pkg::byte_beat_type rx_in;
  level_query_pkg::byte_beat_type tx_out;
  level_query_pkg::auth_req_type  auth_req = '0;
  level_query_pkg::erase_cmd_type erase_cmd;
  logic                           tx_ready;
  logic                           wr = 1'b0;
  logic                           rd = 1'b0;
  logic                           irq;
  logic                           slow = 1'b0;
  logic [3:0]                     addr = 4'h0;
  logic [31:0]                    wdata = 32'h0;
  logic [31:0]                    rdata;
  logic [31:0]                    rv;
  logic [7:0]                     pl;
  logic [7:0]                     al;
  integer                         failures = 0;
  integer                         checked = 0;
  integer                         seed = 32'h4d1d;
  integer                         erases = 0;
  always #25 clk_sys = ~clk_sys;
  level_query_cmd_handler u_level_query_cmd_handler (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_in(rx_in), .tx_ready(tx_ready),
    .tx_out(tx_out), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .auth_req(auth_req), .erase_cmd(erase_cmd), .irq(irq));
  host_tool_model u_host (.clk_sys(clk_sys), .tx_out(tx_out),
    .slow(slow), .rx_in(rx_in), .tx_ready(tx_ready));
  always @(posedge clk_sys) begin
    if (erase_cmd === 3'b111) begin
      erases <= erases + 1;
    end
  end
  task automatic end_of_test;
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic auth(input logic life, input logic ok, input logic [7:0] t);
    @(posedge clk_sys);
    auth_req <= '{valid: 1'b1, key_ok: ok, to_lifecycle: life, target: t};
    @(posedge clk_sys);
    auth_req <= '0;
  endtask
  // Expected reply is built from the codes, never read back from the design
  task automatic query(input logic [7:0] cmd, input logic [15:0] len,
                       input logic [7:0] flip, input logic [7:0] end_b,
                       input logic err, input logic [7:0] res,
                       input logic [7:0] v);
    logic [7:0] body[$];
    logic [7:0] exp[$];
    logic [7:0] s;
    int         n;
    body = {cmd};
    repeat (len - 1) body.push_back(8'h00);
    exp = {8'h81, 8'h00, err ? 8'h0A : 8'h02, res, v};
    if (err) repeat (8) exp.push_back(8'hFF);
    s = 8'h00;
    for (int i = 1; i < exp.size(); i++) s += exp[i];
    exp.push_back(8'h00 - s);
    exp.push_back(8'h03);
    u_host.got.delete();
    u_host.send(len, body, flip, end_b);
    n = 0;
    while (u_host.got.size() < exp.size() && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    cmp("reply length", exp.size(), u_host.got.size());
    foreach (exp[i]) begin
      if (i < u_host.got.size())
        cmp("reply byte", exp[i], u_host.got[i]);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_rd(4'h8, rv);
    cmp("level reg", 32'h00040404, rv);
    u_host.send_byte(8'h55);
    u_host.send_byte(8'h03);
    query(8'h73, 16'h0001, 8'h00, 8'h03, 1'b0, 8'h73, 8'h04);
    for (int i = 0; i < 4; i++) begin
      pl = 8'h02 + 8'($unsigned($random(seed)) % 3);
      al = 8'h02 + 8'($unsigned($random(seed)) % 3);
      slow <= i[0];
      reg_wr(4'h8, {24'h0, pl});
      query(8'h73, 16'h0001, 8'h00, 8'h03, 1'b0, 8'h73, pl);
      auth(1'b0, 1'b1, al);
      query(8'h75, 16'h0001, 8'h00, 8'h03, 1'b0, 8'h75, al);
    end
    query(8'h73, 16'h0001, 8'h00, 8'h7E, 1'b1, 8'hF3, 8'hC1);
    query(8'h75, 16'h0001, 8'h10, 8'h03, 1'b1, 8'hF5, 8'hC2);
    query(8'h73, 16'h0002, 8'h00, 8'h03, 1'b1, 8'hF3, 8'hC1);
    query(8'h75, 16'h0001, 8'h10, 8'h00, 1'b1, 8'hF5, 8'hC1);
    auth(1'b0, 1'b0, 8'h02);
    reg_rd(4'h8, rv);
    cmp("level reg", {8'h00, 8'h04, al, pl}, rv);
    auth(1'b1, 1'b1, 8'h07);
    repeat (2) @(posedge clk_sys);
    cmp("erase pulses", 32'd1, erases);
    reg_rd(4'h8, rv);
    cmp("lifecycle", 32'h07, {24'h0, rv[23:16]});
    reg_rd(4'h0, rv);
    cmp("status", 32'h7, rv);
    reg_wr(4'h4, 32'h1);
    query(8'h73, 16'h0002, 8'h00, 8'h03, 1'b1, 8'hF3, 8'hC1);
    cmp("masked irq", 32'h0, {31'h0, irq});
    query(8'h73, 16'h0001, 8'h00, 8'h03, 1'b0, 8'h73, pl);
    cmp("irq", 32'h1, {31'h0, irq});
    reg_rd(4'h0, rv);
    cmp("status", 32'h3, rv);
    cmp("cleared irq", 32'h0, {31'h0, irq});
    reg_rd(4'h2, rv);
    cmp("unmapped", 32'h0, rv);
    reg_wr(4'hC, 32'h1);
    query(8'h73, 16'h0001, 8'h00, 8'h03, 1'b1, 8'hF3, 8'hC3);
    query(8'h75, 16'h0002, 8'h00, 8'h03, 1'b1, 8'hF5, 8'hC1);
    end_of_test;
  end
endmodule
`default_nettype wire
